/* shared/gcfg_pkg.sv */
// Contract
// - Pull-up select bit 0 gives strong on-key pull-up, 1 gives weak pull-up.
// - Manual reset hold time select: 0 means 8 s, 1 means 4 s.
// - Bias bit 0 forces normal-power main bias, 1 forces low-power.
// - On-key mode: 00 push-button, 01 slide-switch, 10 logic; 11 reserved.
// - Debounce select: 0 gives 500 us filter, 1 gives 30 ms filter.
// - Debounce applies only in push-button and slide-switch modes, not logic mode.
// - Software command 00 does nothing.
// - Command 01 powers down, resets registers, then powers up again.
// - Command 10 powers down, resets registers, then stays off until wake-up.
// - Command 11 powers down, then powers up after the selected wake delay.
// - Timed re-wake keeps every register value unchanged; the code keeps bits 7:2 but returns the command field to 00.
// - Power-down runs 60 ms, 10.24 ms reset delay, four 2.56 ms slots, 125 ms discharge.
// - Wake delay select: 00 100 ms, 01 200 ms, 10 500 ms, 11 1000 ms.
package gcfg_pkg;
    localparam int CLK_MHZ = 40;
    localparam logic [7:0] ADDR_GLOBAL_CONFIG_0 = 8'h06;
    localparam int BIT_PULLUP_WEAK = 7;
    localparam int BIT_HOLD_TIME = 6;
    localparam int BIT_BIAS_LP = 5;
    localparam int MODE_LSB = 3;
    localparam int BIT_DBNC_SEL = 2;
    localparam int CMD_LSB = 0;
    localparam logic [1:0] MODE_BUTTON = 2'h0;
    localparam logic [1:0] MODE_SLIDE = 2'h1;
    localparam logic [1:0] MODE_LOGIC = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_COLD = 2'h1;
    localparam logic [1:0] CMD_OFF = 2'h2;
    localparam logic [1:0] CMD_AUTO = 2'h3;
    localparam logic [1:0] CMD_RESET_VAL = CMD_NONE;
    localparam logic [3:0] RAILS_ALL_ON = 4'hF;
    localparam logic [3:0] RAILS_ALL_OFF = 4'h0;
    localparam int N_SLOTS = 4;
    // Times in microseconds
    localparam int T_DBNC_SHORT_US = 500;
    localparam int T_DBNC_LONG_US = 30000;
    localparam int T_HOLD_LONG_US = 8000000;
    localparam int T_HOLD_SHORT_US = 4000000;
    localparam int T_PD_DELAY_US = 60000;
    localparam int T_RST_DELAY_US = 10240;
    localparam int T_SLOT_US = 2560;
    localparam int T_DISCHARGE_US = 125000;
    localparam int T_WAKE0_US = 100000;
    localparam int T_WAKE1_US = 200000;
    localparam int T_WAKE2_US = 500000;
    localparam int T_WAKE3_US = 1000000;
    // Cycle counts at the core clock rate
    localparam int DBNC_SHORT_CYC = T_DBNC_SHORT_US * CLK_MHZ;
    localparam int DBNC_LONG_CYC = T_DBNC_LONG_US * CLK_MHZ;
    localparam int HOLD_LONG_CYC = T_HOLD_LONG_US * CLK_MHZ;
    localparam int HOLD_SHORT_CYC = T_HOLD_SHORT_US * CLK_MHZ;
    localparam int PD_DELAY_CYC = T_PD_DELAY_US * CLK_MHZ;
    localparam int RST_DELAY_CYC = T_RST_DELAY_US * CLK_MHZ;
    localparam int SLOT_CYC = T_SLOT_US * CLK_MHZ;
    localparam int DISCHARGE_CYC = T_DISCHARGE_US * CLK_MHZ;
    localparam int WAKE0_CYC = T_WAKE0_US * CLK_MHZ;
    localparam int WAKE1_CYC = T_WAKE1_US * CLK_MHZ;
    localparam int WAKE2_CYC = T_WAKE2_US * CLK_MHZ;
    localparam int WAKE3_CYC = T_WAKE3_US * CLK_MHZ;

    typedef enum logic [7:0] {
        ST_ON = 8'h01,
        ST_PD_WAIT = 8'h02,
        ST_RST_DLY = 8'h04,
        ST_SLOT = 8'h08,
        ST_DISCH = 8'h10,
        ST_OFF = 8'h20,
        ST_WAKE_WAIT = 8'h40,
        ST_PWR_UP = 8'h80
    } gcfg_state_e;
endpackage

/* shared/gcfg_ctl_if.sv */
`timescale 1ns/1ps
interface gcfg_ctl_if;
    logic [1:0] key_mode;
    logic dbnc_long;
    logic key_active;
    logic tmr_load;
    logic [31:0] tmr_count;
    logic tmr_done;
    modport key_end (input key_mode, input dbnc_long, output key_active);
    modport tmr_end (input tmr_load, input tmr_count, output tmr_done);
    modport user (output key_mode, output dbnc_long, input key_active,
                  output tmr_load, output tmr_count, input tmr_done);
endinterface

/* hw/gcfg_debounce.sv */
`timescale 1ns/1ps
module gcfg_debounce #(
    parameter int DBNC_SHORT = gcfg_pkg::DBNC_SHORT_CYC,
    parameter int DBNC_LONG = gcfg_pkg::DBNC_LONG_CYC
) (
    input wire logic core_clk,     // Core clock
    input wire logic rst_b,        // Synchronous reset
    input wire logic on_key_input_b, // Raw on-key pin, low is active
    gcfg_ctl_if.key_end ctl        // Mode in, debounced level out
);
    logic key_s1, key_s2, stable;
    logic next_stable;
    logic [31:0] cnt, next_cnt, target;

    if (DBNC_SHORT < 1 || DBNC_LONG < 1) begin : g_bad
        $error("Debounce counts must be at least one cycle");
    end

    always_comb begin
        target = ctl.dbnc_long ? 32'(DBNC_LONG) : 32'(DBNC_SHORT);
        next_stable = stable;
        next_cnt = 32'h0;
        if (ctl.key_mode == gcfg_pkg::MODE_LOGIC) begin
            next_stable = key_s2;
        end else if (key_s2 != stable) begin
            if (cnt >= target - 32'h1) begin
                next_stable = key_s2;
            end else begin
                next_cnt = cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            key_s1 <= 1'b0;
            key_s2 <= 1'b0;
            stable <= 1'b0;
            cnt <= 32'h0;
        end else begin
            key_s1 <= ~on_key_input_b;
            key_s2 <= key_s1;
            stable <= next_stable;
            cnt <= next_cnt;
        end
    end

    assign ctl.key_active = stable;

    chk_logic_bypass: assert property (@(posedge core_clk) disable iff (!rst_b)
        ctl.key_mode == gcfg_pkg::MODE_LOGIC |=> stable == $past(key_s2))
        else $error("Logic mode key level not passed through");
    chk_dbnc_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        ctl.key_mode != gcfg_pkg::MODE_LOGIC && $past(ctl.key_mode) != gcfg_pkg::MODE_LOGIC
        && $changed(stable) |-> $past(cnt) >= $past(target) - 32'h1)
        else $error("Debounced level changed before filter time");
endmodule

/* hw/gcfg_timer.sv */
`timescale 1ns/1ps
module gcfg_timer (
    input wire logic core_clk, // Core clock
    input wire logic rst_b,    // Synchronous reset
    gcfg_ctl_if.tmr_end ctl    // Load, count and done
);
    logic [31:0] cnt, next_cnt;
    logic running, next_running;

    always_comb begin
        next_cnt = cnt;
        next_running = running;
        if (ctl.tmr_load) begin
            next_cnt = ctl.tmr_count - 32'h1;
            next_running = 1'b1;
        end else if (running && cnt == 32'h0) begin
            next_running = 1'b0;
        end else if (running) begin
            next_cnt = cnt - 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt <= 32'h0;
            running <= 1'b0;
        end else begin
            cnt <= next_cnt;
            running <= next_running;
        end
    end

    // Done lands exactly count cycles after the load
    // No load term: the sequencer derives its load from done
    assign ctl.tmr_done = running && cnt == 32'h0;

    chk_timer_load: assert property (@(posedge core_clk) disable iff (!rst_b)
        ctl.tmr_load |=> running && cnt == $past(ctl.tmr_count) - 32'h1)
        else $error("Timer did not load count");
endmodule

/* hw/gcfg_onoff.sv */
`timescale 1ns/1ps
module gcfg_onoff #(
    parameter int DBNC_SHORT = gcfg_pkg::DBNC_SHORT_CYC,
    parameter int DBNC_LONG = gcfg_pkg::DBNC_LONG_CYC,
    parameter int HOLD_LONG = gcfg_pkg::HOLD_LONG_CYC,
    parameter int HOLD_SHORT = gcfg_pkg::HOLD_SHORT_CYC,
    parameter int PD_DELAY = gcfg_pkg::PD_DELAY_CYC,
    parameter int RST_DELAY = gcfg_pkg::RST_DELAY_CYC,
    parameter int SLOT = gcfg_pkg::SLOT_CYC,
    parameter int DISCHARGE = gcfg_pkg::DISCHARGE_CYC,
    parameter int WAKE0 = gcfg_pkg::WAKE0_CYC,
    parameter int WAKE1 = gcfg_pkg::WAKE1_CYC,
    parameter int WAKE2 = gcfg_pkg::WAKE2_CYC,
    parameter int WAKE3 = gcfg_pkg::WAKE3_CYC
) (
    input wire logic core_clk,          // Core clock, 40 MHz
    input wire logic rst_b,             // Synchronous reset, low active
    input wire logic reg_wr,            // Register write strobe
    input wire logic reg_rd,            // Register read strobe
    input wire logic [7:0] reg_addr,    // Register address
    input wire logic [7:0] reg_wdata,   // Write data
    output logic [7:0] reg_rdata,       // Read data, one cycle after strobe
    input wire logic [7:2] otp_default, // Factory defaults for bits 7:2
    input wire logic [1:0] rewake_delay_select, // Wake delay code
    input wire logic on_key_input_b,    // On-key pin, low is active
    output logic pullup_strong_en,      // Strong on-key pull-up enable
    output logic pullup_weak_en,        // Weak on-key pull-up enable
    output logic bias_low_power,        // Main bias low-power mode
    output logic on_key_active,         // Debounced on-key level
    output logic [3:0] rails_en,        // Output rail enables
    output logic discharge_en,          // Output discharge active
    output logic reset_output_b,        // System reset output, low active
    output logic seq_busy               // Power sequence in progress
);
    gcfg_ctl_if ctl ();

    gcfg_pkg::gcfg_state_e state, next_state;
    logic [7:2] cfg, next_cfg;
    logic [1:0] cmd, next_cmd;
    logic [1:0] slot, next_slot;
    logic [31:0] hold_cnt, next_hold_cnt, hold_target;
    logic [3:0] next_rails;
    logic next_rst_out, next_disch;
    logic [7:0] next_rdata;
    logic wr_hit, hold_fire;

    if (PD_DELAY < 1 || RST_DELAY < 1 || SLOT < 1 || DISCHARGE < 1 || HOLD_SHORT < 1 || HOLD_LONG < 1
        || WAKE0 < 1 || WAKE1 < 1 || WAKE2 < 1 || WAKE3 < 1) begin : g_bad
        $error("Sequence counts must be at least one cycle");
    end

    function automatic logic [31:0] wake_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: wake_cycles = 32'(WAKE0);
            2'h1: wake_cycles = 32'(WAKE1);
            2'h2: wake_cycles = 32'(WAKE2);
            default: wake_cycles = 32'(WAKE3);
        endcase
    endfunction

    gcfg_debounce #(
        .DBNC_SHORT(DBNC_SHORT),
        .DBNC_LONG(DBNC_LONG)
    ) u_debounce (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .on_key_input_b(on_key_input_b),
        .ctl(ctl)
    );

    gcfg_timer u_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ctl(ctl)
    );

    assign ctl.key_mode = cfg[gcfg_pkg::MODE_LSB +: 2];
    assign ctl.dbnc_long = cfg[gcfg_pkg::BIT_DBNC_SEL];
    // Writes are refused while a sequence runs; the host is expected to wait
    assign wr_hit = reg_wr && reg_addr == gcfg_pkg::ADDR_GLOBAL_CONFIG_0 && state == gcfg_pkg::ST_ON;

    assign hold_target = cfg[gcfg_pkg::BIT_HOLD_TIME] ? 32'(HOLD_SHORT) : 32'(HOLD_LONG);
    assign hold_fire = state == gcfg_pkg::ST_ON && ctl.key_active
        && cfg[gcfg_pkg::MODE_LSB +: 2] == gcfg_pkg::MODE_BUTTON && hold_cnt >= hold_target - 32'h1;

    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_cmd = cmd;
        next_slot = slot;
        next_rails = rails_en;
        next_rst_out = reset_output_b;
        next_disch = discharge_en;
        ctl.tmr_load = 1'b0;
        ctl.tmr_count = 32'h0;
        next_hold_cnt = 32'h0;
        if (state == gcfg_pkg::ST_ON && ctl.key_active
            && cfg[gcfg_pkg::MODE_LSB +: 2] == gcfg_pkg::MODE_BUTTON) begin
            next_hold_cnt = hold_cnt + 32'h1;
        end
        case (state)
            gcfg_pkg::ST_ON: begin
                if (hold_fire) begin
                    // Button held long enough acts as a cold restart
                    next_cmd = gcfg_pkg::CMD_COLD;
                    next_state = gcfg_pkg::ST_PD_WAIT;
                    ctl.tmr_load = 1'b1;
                    ctl.tmr_count = 32'(PD_DELAY);
                    next_hold_cnt = 32'h0;
                end else if (wr_hit) begin
                    next_cfg[7:5] = reg_wdata[7:5];
                    next_cfg[gcfg_pkg::BIT_DBNC_SEL] = reg_wdata[gcfg_pkg::BIT_DBNC_SEL];
                    if (reg_wdata[gcfg_pkg::MODE_LSB +: 2] != gcfg_pkg::MODE_RSVD) begin
                        next_cfg[gcfg_pkg::MODE_LSB +: 2] = reg_wdata[gcfg_pkg::MODE_LSB +: 2];
                    end
                    if (reg_wdata[gcfg_pkg::CMD_LSB +: 2] != gcfg_pkg::CMD_NONE) begin
                        next_cmd = reg_wdata[gcfg_pkg::CMD_LSB +: 2];
                        next_state = gcfg_pkg::ST_PD_WAIT;
                        ctl.tmr_load = 1'b1;
                        ctl.tmr_count = 32'(PD_DELAY);
                    end
                end
            end
            gcfg_pkg::ST_PD_WAIT: begin
                if (ctl.tmr_done) begin
                    next_state = gcfg_pkg::ST_RST_DLY;
                    ctl.tmr_load = 1'b1;
                    ctl.tmr_count = 32'(RST_DELAY);
                end
            end
            gcfg_pkg::ST_RST_DLY: begin
                if (ctl.tmr_done) begin
                    next_rst_out = 1'b0;
                    next_slot = 2'h0;
                    next_state = gcfg_pkg::ST_SLOT;
                    ctl.tmr_load = 1'b1;
                    ctl.tmr_count = 32'(SLOT);
                end
            end
            gcfg_pkg::ST_SLOT: begin
                if (ctl.tmr_done) begin
                    next_rails[2'h3 - slot] = 1'b0;
                    ctl.tmr_load = 1'b1;
                    if (slot == 2'(gcfg_pkg::N_SLOTS - 1)) begin
                        next_disch = 1'b1;
                        next_state = gcfg_pkg::ST_DISCH;
                        ctl.tmr_count = 32'(DISCHARGE);
                    end else begin
                        next_slot = slot + 2'h1;
                        ctl.tmr_count = 32'(SLOT);
                    end
                end
            end
            gcfg_pkg::ST_DISCH: begin
                if (ctl.tmr_done) begin
                    next_disch = 1'b0;
                    if (cmd != gcfg_pkg::CMD_AUTO) begin
                        next_cfg = otp_default;
                        next_cmd = gcfg_pkg::CMD_RESET_VAL;
                    end
                    if (cmd == gcfg_pkg::CMD_OFF) begin
                        next_state = gcfg_pkg::ST_OFF;
                    end else if (cmd == gcfg_pkg::CMD_AUTO) begin
                        next_state = gcfg_pkg::ST_WAKE_WAIT;
                        ctl.tmr_load = 1'b1;
                        ctl.tmr_count = wake_cycles(rewake_delay_select);
                    end else begin
                        next_slot = 2'h0;
                        next_state = gcfg_pkg::ST_PWR_UP;
                        ctl.tmr_load = 1'b1;
                        ctl.tmr_count = 32'(SLOT);
                    end
                end
            end
            gcfg_pkg::ST_OFF: begin
                if (ctl.key_active) begin
                    next_slot = 2'h0;
                    next_state = gcfg_pkg::ST_PWR_UP;
                    ctl.tmr_load = 1'b1;
                    ctl.tmr_count = 32'(SLOT);
                end
            end
            gcfg_pkg::ST_WAKE_WAIT: begin
                if (ctl.tmr_done) begin
                    next_slot = 2'h0;
                    next_state = gcfg_pkg::ST_PWR_UP;
                    ctl.tmr_load = 1'b1;
                    ctl.tmr_count = 32'(SLOT);
                end
            end
            gcfg_pkg::ST_PWR_UP: begin
                if (ctl.tmr_done) begin
                    next_rails[slot] = 1'b1;
                    if (slot == 2'(gcfg_pkg::N_SLOTS - 1)) begin
                        next_rst_out = 1'b1;
                        next_cmd = gcfg_pkg::CMD_NONE;
                        next_state = gcfg_pkg::ST_ON;
                    end else begin
                        next_slot = slot + 2'h1;
                        ctl.tmr_load = 1'b1;
                        ctl.tmr_count = 32'(SLOT);
                    end
                end
            end
            default: next_state = gcfg_pkg::ST_ON;
        endcase
    end

    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd && reg_addr == gcfg_pkg::ADDR_GLOBAL_CONFIG_0) begin
            next_rdata = {cfg, cmd};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state <= gcfg_pkg::ST_ON;
            cfg <= otp_default;
            cmd <= gcfg_pkg::CMD_RESET_VAL;
            slot <= 2'h0;
            hold_cnt <= 32'h0;
            rails_en <= gcfg_pkg::RAILS_ALL_ON;
            reset_output_b <= 1'b1;
            discharge_en <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            cmd <= next_cmd;
            slot <= next_slot;
            hold_cnt <= next_hold_cnt;
            rails_en <= next_rails;
            reset_output_b <= next_rst_out;
            discharge_en <= next_disch;
            reg_rdata <= next_rdata;
        end
    end

    assign pullup_weak_en = cfg[gcfg_pkg::BIT_PULLUP_WEAK];
    assign pullup_strong_en = ~cfg[gcfg_pkg::BIT_PULLUP_WEAK];
    assign bias_low_power = cfg[gcfg_pkg::BIT_BIAS_LP];
    assign on_key_active = ctl.key_active;
    assign seq_busy = state != gcfg_pkg::ST_ON;

    chk_pullup_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_hit && !hold_fire |=> pullup_weak_en == $past(reg_wdata[7]) && pullup_strong_en != pullup_weak_en)
        else $error("Pull-up select did not follow write");
    chk_hold_start: assert property (@(posedge core_clk) disable iff (!rst_b)
        hold_fire |=> state == gcfg_pkg::ST_PD_WAIT && cmd == gcfg_pkg::CMD_COLD)
        else $error("Manual reset did not start cold restart");
    chk_bias_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_hit && !hold_fire |=> bias_low_power == $past(reg_wdata[5]))
        else $error("Bias mode did not follow write");
    chk_mode_reserved: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_hit && reg_wdata[4:3] == gcfg_pkg::MODE_RSVD |=> $stable(cfg[4:3]))
        else $error("Reserved on-key mode was accepted");
    chk_noop_cmd: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_hit && !hold_fire && reg_wdata[1:0] == gcfg_pkg::CMD_NONE |=> state == gcfg_pkg::ST_ON)
        else $error("No-action command started a sequence");
    chk_cold_reload: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == gcfg_pkg::ST_DISCH && ctl.tmr_done && cmd == gcfg_pkg::CMD_COLD
        |=> state == gcfg_pkg::ST_PWR_UP && cfg == $past(otp_default) && cmd == gcfg_pkg::CMD_NONE)
        else $error("Cold restart did not reset and power up");
    chk_off_stays: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == gcfg_pkg::ST_OFF && !ctl.key_active |=> state == gcfg_pkg::ST_OFF && rails_en == 4'h0)
        else $error("Off state left without wake event");
    chk_auto_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == gcfg_pkg::ST_WAKE_WAIT && ctl.tmr_done |=> state == gcfg_pkg::ST_PWR_UP)
        else $error("Timed re-wake did not start power-up");
    chk_auto_keeps: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd == gcfg_pkg::CMD_AUTO && state != gcfg_pkg::ST_ON |=> $stable(cfg))
        else $error("Registers changed during timed re-wake");
    chk_pd_order: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == gcfg_pkg::ST_PD_WAIT |=> state inside {gcfg_pkg::ST_PD_WAIT, gcfg_pkg::ST_RST_DLY})
        else $error("Power-down delay left out of order");
    chk_slot_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == gcfg_pkg::ST_SLOT |-> !reset_output_b)
        else $error("Reset output not held during power-down slots");
    chk_wake_count: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == gcfg_pkg::ST_DISCH && next_state == gcfg_pkg::ST_WAKE_WAIT
        |-> ctl.tmr_count == wake_cycles(rewake_delay_select))
        else $error("Wrong wake delay loaded");
    chk_reset_cmd: assert property (@(posedge core_clk)
        !rst_b |=> cmd == gcfg_pkg::CMD_NONE && state == gcfg_pkg::ST_ON)
        else $error("Command field not idle after reset");

    cov_cold: cover property (@(posedge core_clk) disable iff (!rst_b)
        cmd == gcfg_pkg::CMD_COLD && state == gcfg_pkg::ST_DISCH ##1 state == gcfg_pkg::ST_PWR_UP);
    cov_off: cover property (@(posedge core_clk) disable iff (!rst_b) state == gcfg_pkg::ST_OFF);
    cov_auto: cover property (@(posedge core_clk) disable iff (!rst_b) state == gcfg_pkg::ST_WAKE_WAIT);
    cov_hold: cover property (@(posedge core_clk) disable iff (!rst_b) hold_fire);
endmodule

/* testbench/gcfg_host_model.sv */
`timescale 1ns/1ps
module gcfg_host_model (
    input wire logic core_clk, // Core clock
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_addr, // Address
    output logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata // Read data
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(negedge core_clk);
        reg_wr <= 1'b0;
        // Released data never shows a stale value
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(negedge core_clk);
        reg_rd <= 1'b0;
        d = reg_rdata;
    endtask
endmodule

/* testbench/gcfg_onoff_tb.sv */
`timescale 1ns/1ps
module gcfg_onoff_tb;
    localparam int DS = 4, DL = 8, ML = 50, MS = 30, SL = 3;
    localparam int WK[4] = '{5, 9, 14, 20};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:2] otp = 6'h00;
    logic [1:0] wsel = 2'h0;
    logic key_b = 1'b1;
    logic reg_wr, reg_rd, pu_s, pu_w, blp, kact, dis, rout_b, busy;
    logic [7:0] addr, wdat, rdat, rv, cfg, w;
    logic [3:0] rails;
    int err_total = 0;
    int cmp_count = 0;
    int n;
    int t[4];
    always #12.5 core_clk = ~core_clk;
    gcfg_host_model i_gcfg_host_model (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(addr), .reg_wdata(wdat), .reg_rdata(rdat));
    gcfg_onoff #(.DBNC_SHORT(DS), .DBNC_LONG(DL), .HOLD_LONG(ML), .HOLD_SHORT(MS), .PD_DELAY(10),
        .RST_DELAY(6), .SLOT(SL), .DISCHARGE(12), .WAKE0(WK[0]), .WAKE1(WK[1]), .WAKE2(WK[2]),
        .WAKE3(WK[3])) i_gcfg_onoff (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdat), .reg_rdata(rdat), .otp_default(otp),
        .rewake_delay_select(wsel), .on_key_input_b(key_b), .pullup_strong_en(pu_s),
        .pullup_weak_en(pu_w), .bias_low_power(blp), .on_key_active(kact), .rails_en(rails),
        .discharge_en(dis), .reset_output_b(rout_b), .seq_busy(busy));
    task automatic summarize();
        $display("Counts: %0d compared, %0d mismatched", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            err_total++;
            $display("FAIL %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    function automatic bit hit(input int k);
        case (k)
            0: hit = kact === 1'b1;
            1: hit = busy === 1'b1;
            2: hit = busy === 1'b0;
            3: hit = dis === 1'b1;
            default: hit = rout_b === 1'b0;
        endcase
    endfunction
    task automatic meas(input int k, output int c);
        c = 0;
        while (!hit(k)) begin
            @(negedge core_clk);
            c++;
            if (c > 5000) begin
                chk_cnt("wait bound", 0, c);
                summarize();
            end
        end
    endtask
    function automatic logic [7:0] exp_cfg(input logic [7:0] old, input logic [7:0] d);
        exp_cfg = {d[7:2], 2'h0};
        // Reserved mode code leaves the stored mode alone
        if (d[4:3] == 2'h3) exp_cfg[4:3] = old[4:3];
    endfunction
    task automatic chk_cfg(input logic [7:0] e);
        i_gcfg_host_model.rd(8'h06, rv);
        chk_byte("config", e, rv);
        chk_byte("pins", {5'h0, ~e[7], e[7], e[5]}, {5'h0, pu_s, pu_w, blp});
    endtask
    initial begin
        void'($urandom(14));
        otp = 6'($urandom()) & 6'h3B;
        repeat (6) @(negedge core_clk);
        rst_b = 1'b1;
        chk_cfg({otp, 2'h0});
        cfg = {otp, 2'h0};
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 8'h18 : 8'($urandom()) & 8'hFC;
            i_gcfg_host_model.wr(8'h06, w);
            cfg = exp_cfg(cfg, w);
            chk_cfg(cfg);
        end
        i_gcfg_host_model.wr(8'h07, 8'hFF);
        i_gcfg_host_model.rd(8'h07, rv);
        chk_byte("unmapped", 8'h00, rv);
        chk_cfg(cfg);
        $display("Test register writes done");
        for (int m = 0; m < 3; m++) begin
            for (int b = 0; b < 2; b++) begin
                i_gcfg_host_model.wr(8'h06, {3'h2, 2'(m), 1'(b), 2'h0});
                key_b = 1'b0;
                meas(0, t[b]);
                key_b = 1'b1;
                repeat (20) @(negedge core_clk);
            end
            chk_cnt("debounce", (m < 2) ? DL - DS : 0, t[1] - t[0]);
        end
        $display("Test debounce done");
        for (int b = 0; b < 2; b++) begin
            i_gcfg_host_model.wr(8'h06, {1'b0, 1'(b), 6'h00});
            key_b = 1'b0;
            meas(1, t[b]);
            key_b = 1'b1;
            meas(2, n);
        end
        chk_cnt("manual reset", ML - MS, t[0] - t[1]);
        $display("Test manual reset done");
        i_gcfg_host_model.wr(8'h06, (8'($urandom()) & 8'hEC) | 8'h01);
        meas(4, n);
        i_gcfg_host_model.wr(8'h06, 8'hFF);
        meas(3, n);
        chk_cnt("slots", 4 * SL - 2, n);
        chk_byte("down", 8'h00, {3'h0, rails, rout_b});
        // Host holds off until the sequence is over
        meas(2, n);
        chk_byte("up", 8'h1F, {3'h0, rails, rout_b});
        chk_cfg({otp, 2'h0});
        $display("Test cold restart done");
        cfg = {otp, 2'h0} ^ 8'hA4;
        i_gcfg_host_model.wr(8'h06, cfg);
        for (int k = 0; k < 4; k++) begin
            wsel = 2'(k);
            i_gcfg_host_model.wr(8'h06, cfg | 8'h03);
            meas(1, n);
            meas(2, t[k]);
            chk_cfg(cfg);
            chk_cnt("wake delay", WK[k] - WK[0], t[k] - t[0]);
        end
        $display("Test timed rewake done");
        i_gcfg_host_model.wr(8'h06, cfg | 8'h02);
        meas(3, n);
        repeat (60) @(negedge core_clk);
        chk_byte("stays off", 8'h10, {3'h0, busy, rails});
        key_b = 1'b0;
        meas(2, n);
        key_b = 1'b1;
        chk_cfg({otp, 2'h0});
        $display("Test power off done");
        summarize();
    end
endmodule
